// *** core/branch_move_pkg.sv ***
// Purpose: Shared constants and types for the branch, call and byte copy executor
// Assumes: 8-bit data path, 16-bit program address, 256-byte internal RAM
// Notes: Opcode patterns for register forms are matched on the upper opcode bits
package branch_move_pkg;

  // Fixed opcodes
  localparam logic [7:0] OP_BR_CARRY_CLEAR = 8'h50;
  localparam logic [7:0] OP_BR_ACC_ZERO = 8'h60;
  localparam logic [7:0] OP_BR_ACC_NONZERO = 8'h70;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_COPY_DIR_ACC = 8'hF5;

  // Patterns on opcode bits 7:3 (register field below)
  localparam logic [4:0] PAT_COPY_ACC_REG = 5'h1D;
  // Patterns on opcode bits 7:1 (pointer select below)
  localparam logic [6:0] PAT_COPY_IND_ACC = 7'h7B;
  localparam logic [6:0] PAT_COPY_IND_DIR = 7'h53;
  localparam logic [6:0] PAT_COPY_IND_IMM = 7'h3B;

  // Instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Machine cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // Instruction classes
  typedef enum logic [3:0] {
    CL_NONE,
    CL_BR_CARRY_CLEAR,
    CL_BR_ACC_ZERO,
    CL_BR_ACC_NONZERO,
    CL_LONG_CALL,
    CL_LONG_JUMP,
    CL_COPY_ACC_REG,
    CL_COPY_DIR_ACC,
    CL_COPY_IND_ACC,
    CL_COPY_IND_DIR,
    CL_COPY_IND_IMM
  } op_class_e;

endpackage

// *** core/opcode_decode.sv ***
// Purpose: Classify one opcode and give its length and machine cycle count
// Assumes: Purely combinational, driven from the fetch path
// Notes: Anything outside the supported group decodes as a one-byte class none
`timescale 1ns/1ps
`default_nettype none
module opcode_decode (
  // Opcode
  input wire logic [7:0] opcode_in,
  // Decode results
  output branch_move_pkg::op_class_e cls_out,
  output logic [1:0] len_out,
  output logic [1:0] cyc_out
);
  import branch_move_pkg::*;

  // Match fixed opcodes first, then the register-field patterns
  always_comb begin
    cls_out = CL_NONE;
    len_out = LEN_ONE;
    cyc_out = CYC_ONE;
    if (opcode_in == OP_BR_CARRY_CLEAR) begin
      cls_out = CL_BR_CARRY_CLEAR;
      len_out = LEN_TWO;
      cyc_out = CYC_TWO;
    end else if (opcode_in == OP_BR_ACC_ZERO) begin
      cls_out = CL_BR_ACC_ZERO;
      len_out = LEN_TWO;
      cyc_out = CYC_TWO;
    end else if (opcode_in == OP_BR_ACC_NONZERO) begin
      cls_out = CL_BR_ACC_NONZERO;
      len_out = LEN_TWO;
      cyc_out = CYC_TWO;
    end else if (opcode_in == OP_LONG_CALL) begin
      cls_out = CL_LONG_CALL;
      len_out = LEN_THREE;
      cyc_out = CYC_TWO;
    end else if (opcode_in == OP_LONG_JUMP) begin
      cls_out = CL_LONG_JUMP;
      len_out = LEN_THREE;
      cyc_out = CYC_TWO;
    end else if (opcode_in == OP_COPY_DIR_ACC) begin
      cls_out = CL_COPY_DIR_ACC;
      len_out = LEN_TWO;
    end else if (opcode_in[7:3] == PAT_COPY_ACC_REG) begin
      cls_out = CL_COPY_ACC_REG;
    end else if (opcode_in[7:1] == PAT_COPY_IND_ACC) begin
      cls_out = CL_COPY_IND_ACC;
    end else if (opcode_in[7:1] == PAT_COPY_IND_DIR) begin
      cls_out = CL_COPY_IND_DIR;
      len_out = LEN_TWO;
      cyc_out = CYC_TWO;
    end else if (opcode_in[7:1] == PAT_COPY_IND_IMM) begin
      cls_out = CL_COPY_IND_IMM;
      len_out = LEN_TWO;
    end
  end

endmodule
`default_nettype wire

// *** core/internal_ram.sv ***
// Purpose: 256-byte internal data RAM holding working registers, stack and data
// Assumes: One access per clock, read data one clock after the request
// Notes: Array has no reset; only the read register is cleared
`timescale 1ns/1ps
`default_nettype none
module internal_ram (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Access port
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  // Read data, registered
  output logic [7:0] rdata_out
);

  logic [7:0] mem_r [0:255]; // Storage
  logic [7:0] rdata_nxt; // Next read word

  // Read path chooses the held word or a fresh read
  always_comb begin
    rdata_nxt = rdata_out;
    if (rd_in) begin
      rdata_nxt = mem_r[addr_in];
    end
  end

  // Storage write, kept free of reset so it maps onto RAM cells
  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem_r[addr_in] <= wdata_in;
    end
  end

  // Read register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// *** core/branch_move_exec.sv ***
// Purpose: Fetch, decode and execute relative branches, long call/jump and byte copies
// Assumes: Program memory answers in the same cycle as the registered fetch address; inputs synchronous
// Notes: Carry and bank select come from outside and are never written here
`timescale 1ns/1ps
`default_nettype none
module branch_move_exec (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  // Program memory fetch
  input wire logic [7:0] PROG_DATA_IN,
  output logic [15:0] PROG_ADDR_OUT,
  // Processor status inputs
  input wire logic CARRY_IN,
  input wire logic [1:0] BANK_IN,
  // Accumulator preload from the rest of the core
  input wire logic ACC_LOAD_IN,
  input wire logic [7:0] ACC_DATA_IN,
  // Architectural state
  output logic [15:0] PC_OUT,
  output logic [7:0] ACC_OUT,
  output logic [7:0] SP_OUT,
  // Retirement report
  output logic RETIRE_OUT,
  output logic [1:0] CYCLES_OUT,
  output logic UNSUPPORTED_OUT
);
  import branch_move_pkg::*;

  typedef enum logic [2:0] {
    ST_ADDR, ST_OP, ST_B2, ST_B3, ST_EXEC, ST_RD_WAIT, ST_RD2_WAIT, ST_PUSH_HI
  } fsm_state_e;

  fsm_state_e state_r, state_nxt; // Sequencer
  logic [15:0] pc_r, pc_nxt; // Program counter
  logic [7:0] sp_r, sp_nxt; // Stack pointer
  logic [7:0] acc_r, acc_nxt; // Accumulator
  logic [7:0] opcode_r, opcode_nxt; // First instruction byte
  logic [7:0] b2_r, b2_nxt; // Second byte
  logic [7:0] b3_r, b3_nxt; // Third byte
  logic [7:0] ptr_r, ptr_nxt; // Indirect address held across a second read
  logic [15:0] prog_addr_r, prog_addr_nxt; // Fetch address
  logic retire_r, retire_nxt; // Retire pulse
  logic [1:0] cycles_r, cycles_nxt; // Reported machine cycles
  logic unsup_r, unsup_nxt; // Unsupported opcode pulse
  logic [7:0] dec_in; // Byte fed to the decoder
  op_class_e cls; // Decoded class
  logic [1:0] len; // Decoded length
  logic [1:0] cyc; // Decoded cycle count
  logic mem_rd, mem_wr; // RAM strobes
  logic [7:0] mem_addr, mem_wdata; // RAM address and data
  logic [7:0] mem_rdata; // RAM read word
  logic [7:0] reg_addr; // Working register address in the current bank
  logic [7:0] ptr_addr; // Pointer register address in the current bank
  logic [15:0] rel_target; // Relative branch destination
  logic [15:0] abs_target; // Absolute destination from bytes two and three

  // Decode the byte on the bus while it arrives, the held opcode afterwards
  assign dec_in = (state_r == ST_OP) ? PROG_DATA_IN : opcode_r;

  opcode_decode u_decode (
    .opcode_in(dec_in),
    .cls_out(cls),
    .len_out(len),
    .cyc_out(cyc)
  );

  internal_ram u_ram (
    .clk_in(CLK_SYS_IN),
    .reset_in(RESET_IN),
    .rd_in(mem_rd),
    .wr_in(mem_wr),
    .addr_in(mem_addr),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );

  // Bank select sits above the register field, as in the usual register layout
  assign reg_addr = {3'h0, BANK_IN, opcode_r[2:0]};
  assign ptr_addr = {3'h0, BANK_IN, 2'h0, opcode_r[0]};
  // PC already points past the instruction; the sum is cut to 16 bits to wrap
  assign rel_target = 16'(pc_r + {{8{b2_r[7]}}, b2_r});
  assign abs_target = {b2_r, b3_r};

  // Next-state logic for the sequencer and all architectural state
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    acc_nxt = ACC_LOAD_IN ? ACC_DATA_IN : acc_r;
    opcode_nxt = opcode_r;
    b2_nxt = b2_r;
    b3_nxt = b3_r;
    ptr_nxt = ptr_r;
    prog_addr_nxt = prog_addr_r;
    retire_nxt = 1'b0;
    cycles_nxt = cycles_r;
    unsup_nxt = 1'b0;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
    unique case (state_r)
      // Present the instruction address
      ST_ADDR: begin
        prog_addr_nxt = pc_r;
        state_nxt = ST_OP;
      end
      // Opcode arrives; each byte fetched advances the PC once
      ST_OP: begin
        opcode_nxt = PROG_DATA_IN;
        pc_nxt = 16'(pc_r + 16'h0001);
        prog_addr_nxt = 16'(pc_r + 16'h0001);
        state_nxt = (len == LEN_ONE) ? ST_EXEC : ST_B2;
      end
      // Second byte: displacement, direct address, constant or high address half
      ST_B2: begin
        b2_nxt = PROG_DATA_IN;
        pc_nxt = 16'(pc_r + 16'h0001);
        prog_addr_nxt = 16'(pc_r + 16'h0001);
        state_nxt = (len == LEN_THREE) ? ST_B3 : ST_EXEC;
      end
      // Third byte: low address half
      ST_B3: begin
        b3_nxt = PROG_DATA_IN;
        pc_nxt = 16'(pc_r + 16'h0001);
        state_nxt = ST_EXEC;
      end
      // Execute; most classes finish here
      ST_EXEC: begin
        state_nxt = ST_ADDR;
        retire_nxt = 1'b1;
        cycles_nxt = cyc;
        unique case (cls)
          // Carry is only read here, never driven
          CL_BR_CARRY_CLEAR: begin
            if (!CARRY_IN) begin
              pc_nxt = rel_target;
            end
          end
          // Accumulator only read, so its value and flags stay put
          CL_BR_ACC_ZERO: begin
            if (acc_r == 8'h00) begin
              pc_nxt = rel_target;
            end
          end
          CL_BR_ACC_NONZERO: begin
            if (acc_r != 8'h00) begin
              pc_nxt = rel_target;
            end
          end
          // First push: return address low byte after pre-increment
          CL_LONG_CALL: begin
            mem_wr = 1'b1;
            mem_addr = 8'(sp_r + 8'h01);
            mem_wdata = pc_r[7:0];
            sp_nxt = 8'(sp_r + 8'h01);
            state_nxt = ST_PUSH_HI;
            retire_nxt = 1'b0;
          end
          CL_LONG_JUMP: begin
            pc_nxt = abs_target;
          end
          CL_COPY_DIR_ACC: begin
            mem_wr = 1'b1;
            mem_addr = b2_r;
            mem_wdata = acc_r;
          end
          // Register read first; destination handled when data returns
          CL_COPY_ACC_REG: begin
            mem_rd = 1'b1;
            mem_addr = reg_addr;
            state_nxt = ST_RD_WAIT;
            retire_nxt = 1'b0;
          end
          CL_COPY_IND_ACC, CL_COPY_IND_DIR, CL_COPY_IND_IMM: begin
            mem_rd = 1'b1;
            mem_addr = ptr_addr;
            state_nxt = ST_RD_WAIT;
            retire_nxt = 1'b0;
          end
          // Outside this group: skipped as a one-byte no-op and flagged
          CL_NONE: begin
            unsup_nxt = 1'b1;
          end
          default: begin
            unsup_nxt = 1'b1;
          end
        endcase
      end
      // First read word is ready
      ST_RD_WAIT: begin
        state_nxt = ST_ADDR;
        retire_nxt = 1'b1;
        cycles_nxt = cyc;
        unique case (cls)
          CL_COPY_ACC_REG: begin
            acc_nxt = mem_rdata;
          end
          CL_COPY_IND_ACC: begin
            mem_wr = 1'b1;
            mem_addr = mem_rdata;
            mem_wdata = acc_r;
          end
          CL_COPY_IND_IMM: begin
            mem_wr = 1'b1;
            mem_addr = mem_rdata;
            mem_wdata = b2_r;
          end
          // Keep the pointer, then fetch the direct source
          CL_COPY_IND_DIR: begin
            ptr_nxt = mem_rdata;
            mem_rd = 1'b1;
            mem_addr = b2_r;
            state_nxt = ST_RD2_WAIT;
            retire_nxt = 1'b0;
          end
          default: begin
            state_nxt = ST_ADDR;
          end
        endcase
      end
      // Direct source ready: store it through the pointer
      ST_RD2_WAIT: begin
        mem_wr = 1'b1;
        mem_addr = ptr_r;
        mem_wdata = mem_rdata;
        state_nxt = ST_ADDR;
        retire_nxt = 1'b1;
        cycles_nxt = cyc;
      end
      // Second push: high byte, then take the call target
      ST_PUSH_HI: begin
        mem_wr = 1'b1;
        mem_addr = 8'(sp_r + 8'h01);
        mem_wdata = pc_r[15:8];
        sp_nxt = 8'(sp_r + 8'h01);
        pc_nxt = abs_target;
        state_nxt = ST_ADDR;
        retire_nxt = 1'b1;
        cycles_nxt = cyc;
      end
    endcase
  end

  // State registers
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_r <= ST_ADDR;
      pc_r <= PC_RESET;
      sp_r <= SP_RESET;
      acc_r <= ACC_RESET;
      opcode_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      ptr_r <= 8'h00;
      prog_addr_r <= PC_RESET;
      retire_r <= 1'b0;
      cycles_r <= 2'h0;
      unsup_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      acc_r <= acc_nxt;
      opcode_r <= opcode_nxt;
      b2_r <= b2_nxt;
      b3_r <= b3_nxt;
      ptr_r <= ptr_nxt;
      prog_addr_r <= prog_addr_nxt;
      retire_r <= retire_nxt;
      cycles_r <= cycles_nxt;
      unsup_r <= unsup_nxt;
    end
  end

  // Outputs straight from flops
  assign PROG_ADDR_OUT = prog_addr_r;
  assign PC_OUT = pc_r;
  assign ACC_OUT = acc_r;
  assign SP_OUT = sp_r;
  assign RETIRE_OUT = retire_r;
  assign CYCLES_OUT = cycles_r;
  assign UNSUPPORTED_OUT = unsup_r;

  // Helper: address of the instruction being executed
  logic [15:0] start_pc_r;
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      start_pc_r <= PC_RESET;
    end else if (state_r == ST_ADDR) begin
      start_pc_r <= pc_r;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_exec(op_class_e c);
    state_r == ST_EXEC && cls == c;
  endsequence

  sequence s_push_lo;
    mem_wr && mem_addr == 8'(sp_r + 8'h01) && mem_wdata == pc_r[7:0];
  endsequence

  sequence s_push_hi;
    mem_wr && mem_addr == 8'(sp_r + 8'h01) && mem_wdata == $past(pc_r[15:8]);
  endsequence

  a_carry_clear_taken: assert property (
    s_exec(CL_BR_CARRY_CLEAR) and (!CARRY_IN) |=>
      pc_r == 16'($past(start_pc_r) + 16'h0002 + {{8{$past(b2_r[7])}}, $past(b2_r)}))
    else $error("carry clear branch target wrong");

  a_carry_set_falls: assert property (
    s_exec(CL_BR_CARRY_CLEAR) and CARRY_IN |=> pc_r == 16'($past(start_pc_r) + 16'h0002))
    else $error("carry set branch did not fall through");

  a_fetch_length: assert property (
    state_r == ST_EXEC |-> pc_r == 16'(start_pc_r + {14'h0000, len}))
    else $error("pc not advanced by instruction length");

  // Expected PC built from the start address, so a wrong fetch length cannot pass as a correct decision
  a_acc_nonzero_br: assert property (
    s_exec(CL_BR_ACC_NONZERO) |=>
      pc_r == (($past(acc_r) != 8'h00) ?
        16'($past(start_pc_r) + 16'h0002 + {{8{$past(b2_r[7])}}, $past(b2_r)}) :
        16'($past(start_pc_r) + 16'h0002)))
    else $error("nonzero branch decision wrong");

  a_acc_zero_br: assert property (
    s_exec(CL_BR_ACC_ZERO) |-> cyc == CYC_TWO && len == LEN_TWO ##1
      pc_r == (($past(acc_r) == 8'h00) ?
        16'($past(start_pc_r) + 16'h0002 + {{8{$past(b2_r[7])}}, $past(b2_r)}) :
        16'($past(start_pc_r) + 16'h0002)))
    else $error("zero branch decision wrong");

  a_acc_untouched: assert property (
    (s_exec(CL_BR_ACC_ZERO) or s_exec(CL_BR_ACC_NONZERO)) and !ACC_LOAD_IN |=>
      $stable(acc_r))
    else $error("accumulator changed by test branch");

  a_call_push: assert property (
    s_exec(CL_LONG_CALL) |-> s_push_lo ##1 ((state_r == ST_PUSH_HI) and s_push_hi)
      ##1 sp_r == 8'($past(sp_r, 2) + 8'h02))
    else $error("call push sequence wrong");

  a_call_target: assert property (
    s_exec(CL_LONG_CALL) |-> pc_r == 16'(start_pc_r + 16'h0003) ##2 pc_r == {b2_r, b3_r})
    else $error("call return or target wrong");

  a_jump_target: assert property (
    s_exec(CL_LONG_JUMP) |=> pc_r == {$past(b2_r), $past(b3_r)} && retire_r)
    else $error("long jump target wrong");

  a_dir_write: assert property (
    s_exec(CL_COPY_DIR_ACC) |-> mem_wr && mem_addr == b2_r && mem_wdata == acc_r)
    else $error("direct copy write wrong");

  a_imm_indirect: assert property (
    s_exec(CL_COPY_IND_IMM) |-> mem_addr == ptr_addr ##1
      (mem_wr && mem_addr == mem_rdata && mem_wdata == b2_r))
    else $error("immediate indirect copy wrong");

endmodule
`default_nettype wire

// *** dv/prog_rom_model.sv ***
// Purpose: Program memory model for the fetch side of the branch and copy executor
// Assumes: Read of the registered fetch address, data valid while that address stands
// Notes: Unloaded bytes read as 00, an opcode outside the tested group
`timescale 1ns/1ps
`default_nettype none
module prog_rom_model (
  // Clock
  input wire logic clk_in,
  // Fetch port
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out
);
  // Program image, written by the bench between scenarios
  logic [7:0] mem [0:65535];

  // Blank image, so a stray fetch never feeds an unknown opcode
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  // The fetch address is already a flop, so the byte must stand in the same cycle;
  // an extra register here would hand the sequencer the previous address's byte
  assign data_out = mem[addr_in];
endmodule
`default_nettype wire

// *** dv/branch_move_exec_bench.sv ***
// Purpose: Self-checking bench for the branch, call, jump and byte copy executor
// Assumes: Program memory model answers while each registered fetch address stands
// Notes: RAM is seen only through copies into the accumulator
`timescale 1ns/1ps
`default_nettype none
module branch_move_exec_bench;
  // Design side signals
  logic clk_sys = 1'b0;
  logic reset;
  logic carry;
  logic [1:0] bank;
  logic acc_load;
  logic [7:0] acc_data;
  logic [7:0] prog_data;
  logic [15:0] prog_addr;
  logic [15:0] pc;
  logic [7:0] acc;
  logic [7:0] sp;
  logic retire;
  logic [1:0] cycles;
  logic unsup;
  // Score keeping
  int mismatches;
  int compares;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  branch_move_exec u_branch_move_exec (
    .CLK_SYS_IN(clk_sys), .RESET_IN(reset), .PROG_DATA_IN(prog_data),
    .PROG_ADDR_OUT(prog_addr), .CARRY_IN(carry), .BANK_IN(bank),
    .ACC_LOAD_IN(acc_load), .ACC_DATA_IN(acc_data), .PC_OUT(pc), .ACC_OUT(acc),
    .SP_OUT(sp), .RETIRE_OUT(retire), .CYCLES_OUT(cycles), .UNSUPPORTED_OUT(unsup)
  );

  prog_rom_model u_prog_rom_model (
    .clk_in(clk_sys), .addr_in(prog_addr), .data_out(prog_data)
  );

  // Compare one value, report and count a mismatch
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Place bytes in program memory from the given address
  task automatic load(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) begin
      u_prog_rom_model.mem[a + 16'(i)] = b[i];
    end
  endtask

  // Reset the core, then preload the accumulator on the first free edge
  task automatic restart(input logic [7:0] acc_v, input logic carry_v, input logic [1:0] bank_v);
    @(posedge clk_sys);
    reset <= 1'b1;
    carry <= carry_v;
    bank <= bank_v;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    acc_load <= 1'b1;
    acc_data <= acc_v;
    @(posedge clk_sys);
    acc_load <= 1'b0;
  endtask

  // Bounded wait for the one-cycle retire pulse, sampled after the edge settles
  task automatic wait_retire();
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (retire !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (retire !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, retire, 1'b1);
      stop_test();
    end
  endtask

  // Retire one instruction and compare the architectural state
  task automatic exec_chk(input logic [15:0] e_pc, input logic [7:0] e_acc,
                          input logic [7:0] e_sp, input logic [1:0] e_cyc);
    wait_retire();
    check(pc, e_pc);
    check({8'h00, acc}, {8'h00, e_acc});
    check({8'h00, sp}, {8'h00, e_sp});
    check({14'h0000, cycles}, {14'h0000, e_cyc});
    check({15'h0000, unsup}, 16'h0000);
    // Next fetch must go to the new program counter
    @(posedge clk_sys);
    #1;
    check(prog_addr, e_pc);
  endtask

  // One conditional branch at address zero
  task automatic br_case(input logic [7:0] op, input logic c, input logic [7:0] a,
                         input logic [7:0] d, input logic [15:0] e_pc);
    load(16'h0000, '{op, d});
    restart(a, c, 2'h0);
    exec_chk(e_pc, a, 8'h07, 2'h2);
  endtask

  // Taken and fall-through forms of all three branches, wrap below zero
  task automatic test_branches();
    br_case(8'h50, 1'b0, 8'h00, 8'h05, 16'h0007);
    br_case(8'h50, 1'b1, 8'h00, 8'h05, 16'h0002);
    br_case(8'h50, 1'b0, 8'h5A, 8'h7F, 16'h0081);
    br_case(8'h60, 1'b0, 8'h00, 8'hFE, 16'h0000);
    br_case(8'h60, 1'b1, 8'h01, 8'hFE, 16'h0002);
    br_case(8'h70, 1'b0, 8'h80, 8'h80, 16'hFF82);
    br_case(8'h70, 1'b1, 8'h00, 8'h80, 16'h0002);
    $display("branch test done");
  endtask

  // Jump, call with push into bank 1, read the pushed bytes back
  task automatic test_call();
    load(16'h0000, '{8'h02, 8'h01, 8'h23});
    load(16'h0123, '{8'h12, 8'h12, 8'h34});
    load(16'h1234, '{8'hE8, 8'hE9, 8'hA5});
    restart(8'h00, 1'b0, 2'h1);
    exec_chk(16'h0123, 8'h00, 8'h07, 2'h2);
    exec_chk(16'h1234, 8'h00, 8'h09, 2'h2);
    exec_chk(16'h1235, 8'h26, 8'h09, 2'h1);
    exec_chk(16'h1236, 8'h01, 8'h09, 2'h1);
    // Opcode outside the group: one byte, nothing changes
    wait_retire();
    check(pc, 16'h1237);
    check({15'h0000, unsup}, 16'h0001);
    check({8'h00, acc}, 16'h0001);
    $display("call test done");
  endtask

  // Chain of copies through pointers, immediates and direct addresses
  task automatic test_copies();
    load(16'h0000, '{8'hF5, 8'h00, 8'h76, 8'h07, 8'hEB, 8'hF5, 8'h01, 8'h77, 8'hC3,
                     8'hEF, 8'hF6, 8'hA7, 8'h00, 8'hEF, 8'hEB});
    restart(8'h03, 1'b1, 2'h0);
    exec_chk(16'h0002, 8'h03, 8'h07, 2'h1);
    exec_chk(16'h0004, 8'h03, 8'h07, 2'h1);
    exec_chk(16'h0005, 8'h07, 8'h07, 2'h1);
    exec_chk(16'h0007, 8'h07, 8'h07, 2'h1);
    exec_chk(16'h0009, 8'h07, 8'h07, 2'h1);
    exec_chk(16'h000A, 8'hC3, 8'h07, 2'h1);
    exec_chk(16'h000B, 8'hC3, 8'h07, 2'h1);
    exec_chk(16'h000D, 8'hC3, 8'h07, 2'h2);
    exec_chk(16'h000E, 8'h03, 8'h07, 2'h1);
    exec_chk(16'h000F, 8'hC3, 8'h07, 2'h1);
    $display("copy test done");
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    carry = 1'b0;
    bank = 2'h0;
    acc_load = 1'b0;
    acc_data = 8'h00;
    mismatches = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    test_branches();
    test_call();
    test_copies();
    stop_test();
  end
endmodule
`default_nettype wire
